// ---- pscr_consts.svh ----
// Purpose: Constants for the pack status and cycle register bank
// Assumes: 50 MHz core clock
// Notes:   Offsets are read-word command codes
//
// How it works
// - Init flag low until first one-second update
// - Drain set after quiet current for relax time
// - Drain set on quiet current after termination
// - Drain set on quiet current, charge switch off
// - Drain set at or below negated discharge threshold
// - Drain cleared at or above charge threshold
// - Error 0 for success, 1 for busy
// - Error 2 reserved, 3 unsupported command
// - Error 4 read-only write, 5 range fault
// - Error 6 bad size, 7 unknown fault
// - Cycle count saturates, copied to store on increment
// - Cycle threshold fixed amount or capacity percent
// - Host writes allowed only while unsealed
// - Design capacity from mAh or energy setting
// - Design voltage 14400 default, 7000 to 18000
// - Spec word nibble packing, default 0x0031
// - Power scale is product of both scales
// - Status word layout on command 0x16
// - Low alarms from current or power by mode
`ifndef PSCR_CONSTS_SVH
`define PSCR_CONSTS_SVH

// ==========================================================
// Command codes
`define PSCR_CMD_STATUS   8'h16
`define PSCR_CMD_CYCLE    8'h17
`define PSCR_CMD_DCAP     8'h18
`define PSCR_CMD_DVOLT    8'h19
`define PSCR_CMD_SPEC     8'h1a
`define PSCR_CMD_RSV_LO   8'h70
`define PSCR_CMD_RSV_HI   8'h7f

// ==========================================================
// Reset values
`define PSCR_CYCLE_RST    16'h0000
`define PSCR_DCAP_RST     16'h1130
`define PSCR_DENERGY_RST  16'h1130
`define PSCR_DVOLT_RST    16'h3840
`define PSCR_SPEC_RST     16'h0031
`define PSCR_AMOUNT_RST   16'h1130
`define PSCR_PCT_RST      7'h5a

// ==========================================================
// Limits
`define PSCR_CYCLE_MAX    16'hfffe
`define PSCR_DVOLT_MIN    16'h1b58
`define PSCR_DVOLT_MAX    16'h4650
`define PSCR_PCT_DIV      24'h000064

// ==========================================================
// Spec word fields
`define PSCR_SPEC_VSC_LSB 8
`define PSCR_SPEC_ISC_LSB 12

// ==========================================================
// Error codes
`define PSCR_EC_OK        4'h0
`define PSCR_EC_BUSY      4'h1
`define PSCR_EC_RSVD      4'h2
`define PSCR_EC_UNSUP     4'h3
`define PSCR_EC_DENIED    4'h4
`define PSCR_EC_RANGE     4'h5
`define PSCR_EC_SIZE      4'h6
`define PSCR_EC_UNKNOWN   4'h7

// ==========================================================
// Store word indexes
`define PSCR_NV_CYCLE     3'h0
`define PSCR_NV_DCAP      3'h1
`define PSCR_NV_DENERGY   3'h2
`define PSCR_NV_DVOLT     3'h3
`define PSCR_NV_SPEC      3'h4

// ==========================================================
// Timing
`define PSCR_CLK_MHZ      50
`define PSCR_SEC_MS       1000
`define PSCR_SEC_CYCLES   (`PSCR_SEC_MS * 1000 * `PSCR_CLK_MHZ)
`define PSCR_NV_WR_CYCLES 4'h4

`endif

// ---- pscr_host_model.sv ----
// Purpose: Host side model that issues word commands to the bank
// Assumes: One command in flight, answer within a few cycles
// Notes:   Released command lines show an inverted pattern
`timescale 1ns/1ps
`default_nettype none

module pscr_host_model (
    input  wire logic                rsp_valid_in,  // Answer pulse
    input  wire logic        [15:0]  rsp_data_in,   // Answer word
    input  wire logic                clk_in,        // Bus clock
    output var  logic                cmd_valid_out, // Command strobe
    output var  pscr_pkg::pscr_cmd_t cmd_out        // Command fields
);
    import pscr_pkg::*;

    // ==========================================================
    // Idle bus at time zero
    initial begin
        cmd_valid_out = 1'b0;
        cmd_out = '0;
    end

    // One transfer; fl is {write, abort, bad_size}
    task automatic xfer(input logic [7:0] code, input logic [15:0] wd,
                        input logic [2:0] fl, output logic [15:0] rd);
        int n;
        if (code == 8'h1a) wd[15:8] = 8'h00;
        @(posedge clk_in);
        cmd_valid_out <= 1'b1;
        cmd_out <= '{fl[2], code, wd, fl[0], fl[1]};
        @(posedge clk_in);
        cmd_valid_out <= 1'b0;
        cmd_out <= ~cmd_out; // Stale fields must not look valid
        n = 0;
        while (rsp_valid_in !== 1'b1 && n < 8) begin
            @(negedge clk_in);
            n++;
        end
        rd = rsp_data_in;
    endtask
endmodule // pscr_host_model

`default_nettype wire

// ---- pscr_nvstore.sv ----
// Purpose: Nonvolatile backing store image of the configuration words
// Assumes: One write and one read per clock
// Notes:   Read data are registered, one cycle after the address
`timescale 1ns/1ps
`default_nettype none
`include "pscr_consts.svh"

module pscr_nvstore (
    input  wire logic        core_clk_in,  // System clock
    input  wire logic        sys_rst_in,   // Sync reset, high
    input  wire logic        wr_en_in,     // Write strobe
    input  wire logic [2:0]  wr_addr_in,   // Write word index
    input  wire logic [15:0] wr_data_in,   // Write data
    input  wire logic [2:0]  rd_addr_in,   // Read word index
    output logic      [15:0] rd_data_out   // Registered read data
);
    logic [15:0] mem [0:4];

    // =================================================
    // Storage, reset to the configured defaults
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            mem[`PSCR_NV_CYCLE]   <= `PSCR_CYCLE_RST;
            mem[`PSCR_NV_DCAP]    <= `PSCR_DCAP_RST;
            mem[`PSCR_NV_DENERGY] <= `PSCR_DENERGY_RST;
            mem[`PSCR_NV_DVOLT]   <= `PSCR_DVOLT_RST;
            mem[`PSCR_NV_SPEC]    <= `PSCR_SPEC_RST;
        end else if (wr_en_in && wr_addr_in <= `PSCR_NV_SPEC) begin
            mem[wr_addr_in] <= wr_data_in;
        end
    end

    // Read port; unused indexes read zero
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            rd_data_out <= 16'h0000;
        end else if (rd_addr_in <= `PSCR_NV_SPEC) begin
            rd_data_out <= mem[rd_addr_in];
        end else begin
            rd_data_out <= 16'h0000;
        end
    end
endmodule // pscr_nvstore

`default_nettype wire

// ---- pscr_pkg.sv ----
// Purpose: Types for the pack status and cycle register bank
// Assumes: Nothing beyond the constants header
// Notes:   Structs carry grouped signals across ports
package pscr_pkg;

    // Host command as taken from the serial front end
    typedef struct packed {
        logic        write;
        logic [7:0]  code;
        logic [15:0] wdata;
        logic        bad_size;
        logic        abort;
    } pscr_cmd_t;

    // Alarm and flag inputs from the gauging engine
    typedef struct packed {
        logic overcharge_alarm;
        logic stop_charge_alarm;
        logic overheat_alarm;
        logic stop_discharge_alarm;
        logic low_capacity_alarm_i;
        logic low_capacity_alarm_p;
        logic low_time_alarm_i;
        logic low_time_alarm_p;
        logic full_flag;
        logic empty_flag;
    } pscr_gauge_t;

    // Backing store write mirror state
    typedef enum logic [1:0] {
        NV_IDLE = 2'b01,
        NV_BUSY = 2'b10
    } pscr_nv_state_t;

endpackage

// ---- pscr_regs.sv ----
// Purpose: Status word, cycle counter and design words of a gas gauge
// Assumes: Commands arrive one at a time, at least two cycles apart
// Notes:   Alarm values come from the gauging engine outside
`timescale 1ns/1ps
`default_nettype none
`include "pscr_consts.svh"

module pscr_regs #(
    parameter int SEC_CYCLES = `PSCR_SEC_CYCLES  // One-second period
) (
    input  wire logic                core_clk_in,     // 50 MHz clock
    input  wire logic                sys_rst_in,      // Full reset
    input  wire logic                cmd_valid_in,    // Command strobe
    input  wire pscr_pkg::pscr_cmd_t cmd_in,          // Command fields
    input  wire pscr_pkg::pscr_gauge_t gauge_in,      // Engine flags
    input  wire logic signed [15:0]  current_ma_in,   // Measured mA
    input  wire logic        [15:0]  quit_ma_in,      // Quit current
    input  wire logic        [15:0]  dsg_detect_ma_in, // Discharge det.
    input  wire logic        [15:0]  chg_detect_ma_in, // Charge det.
    input  wire logic        [7:0]   relax_s_in,      // Relax time, s
    input  wire logic                chg_term_in,     // Termination seen
    input  wire logic                charge_switch_in, // Switch on
    input  wire logic                sealed_in,       // Sealed flag
    input  wire logic                capacity_mode_in, // 1: energy
    input  wire logic                cycle_threshold_select_in, // 1: %
    input  wire logic        [15:0]  cycle_discharge_amount_in, // mAh
    input  wire logic        [6:0]   cycle_discharge_percent_in, // %
    input  wire logic        [15:0]  full_cap_in,     // Full capacity
    input  wire logic                dsg_mah_pulse_in, // 1 mAh drained
    output logic                     rsp_valid_out,   // Answer pulse
    output logic             [15:0]  rsp_data_out,    // Answer word
    output logic             [15:0]  pack_status_word_out, // Status
    output logic             [4:0]   power_scale_exp_out, // 10^n
    output logic                     nv_busy_out      // Store busy
);
    import pscr_pkg::*;

    logic        init_done_flag;
    logic        draining_flag;
    logic [3:0]  error_code_field;
    logic [15:0] cycle_counter;
    logic [31:0] sec_cnt;
    logic        sec_tick;
    logic [7:0]  relax_cnt;
    logic [16:0] dsg_accum;
    logic        pend;
    pscr_cmd_t   cmd_q;
    logic        copy_pend;
    pscr_nv_state_t nv_state;
    logic [3:0]  nv_cnt;
    logic [15:0] nv_rd_data;
    logic        nv_wr_en;
    logic [2:0]  nv_wr_addr;
    logic [15:0] nv_wr_data;
    logic [2:0]  nv_rd_addr;
    logic [3:0]  next_ec;
    logic        host_wr;
    logic        inc_now;
    logic [15:0] cyc_thresh;
    logic [22:0] pct_prod;

    // Command code to store index, used by read and write paths
    function automatic logic [2:0] nv_index(input logic [7:0] code,
                                            input logic       emode);
        unique case (code)
            `PSCR_CMD_DCAP:  nv_index = emode ? `PSCR_NV_DENERGY
                                              : `PSCR_NV_DCAP;
            `PSCR_CMD_DVOLT: nv_index = `PSCR_NV_DVOLT;
            `PSCR_CMD_SPEC:  nv_index = `PSCR_NV_SPEC;
            default:         nv_index = `PSCR_NV_CYCLE;
        endcase
    endfunction

    // True for the command codes this bank owns
    function automatic logic own_code(input logic [7:0] code);
        own_code = code >= `PSCR_CMD_STATUS && code <= `PSCR_CMD_SPEC;
    endfunction

    // =================================================
    // One-second time base and initialisation
    assign sec_tick = (sec_cnt == 32'(SEC_CYCLES - 1));

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            sec_cnt <= 32'h0000_0000;
        end else if (sec_tick) begin
            sec_cnt <= 32'h0000_0000;
        end else begin
            sec_cnt <= sec_cnt + 32'h0000_0001;
        end
    end

    // First full update pass ends at the first second boundary
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            init_done_flag <= 1'b0;
        end else if (sec_tick) begin
            init_done_flag <= 1'b1;
        end
    end

    // =================================================
    // Discharge state detection
    logic quiet;
    logic dsg_det;
    logic chg_det;
    assign quiet   = 17'(signed'(current_ma_in)) <=
                     signed'({1'b0, quit_ma_in});
    assign dsg_det = 17'(signed'(current_ma_in)) <=
                     -signed'({1'b0, dsg_detect_ma_in});
    assign chg_det = 17'(signed'(current_ma_in)) >=
                     signed'({1'b0, chg_detect_ma_in});

    // Seconds spent continuously at or below quit current
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in || !quiet) begin
            relax_cnt <= 8'h00;
        end else if (sec_tick && relax_cnt != 8'hff) begin
            relax_cnt <= relax_cnt + 8'h01;
        end
    end

    // Clear has priority; neither condition keeps the old value
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            draining_flag <= 1'b0;
        end else if (chg_det) begin
            draining_flag <= 1'b0;
        end else if (quiet && relax_cnt >= relax_s_in) begin
            draining_flag <= 1'b1;
        end else if (quiet && chg_term_in) begin
            draining_flag <= 1'b1;
        end else if (quiet && !charge_switch_in) begin
            draining_flag <= 1'b1;
        end else if (dsg_det) begin
            draining_flag <= 1'b1;
        end
    end

    // =================================================
    // Cycle counting on accumulated discharge
    assign pct_prod   = 23'(full_cap_in) * 23'(cycle_discharge_percent_in);
    assign cyc_thresh = cycle_threshold_select_in
                      ? 16'(24'(pct_prod) / `PSCR_PCT_DIV)
                      : cycle_discharge_amount_in;
    assign inc_now    = dsg_mah_pulse_in && cyc_thresh != 16'h0000 &&
                        dsg_accum + 17'h00001 >= {1'b0, cyc_thresh};

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            dsg_accum <= 17'h00000;
        end else if (inc_now) begin
            dsg_accum <= 17'h00000;
        end else if (dsg_mah_pulse_in && dsg_accum != 17'h1ffff) begin
            dsg_accum <= dsg_accum + 17'h00001;
        end
    end

    // Host write wins over a same-cycle increment
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            cycle_counter <= `PSCR_CYCLE_RST;
        end else if (host_wr && cmd_q.code == `PSCR_CMD_CYCLE) begin
            cycle_counter <= cmd_q.wdata;
        end else if (inc_now && cycle_counter < `PSCR_CYCLE_MAX) begin
            cycle_counter <= cycle_counter + 16'h0001;
        end
    end

    // Copy request; a new increment wins over the clear
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            copy_pend <= 1'b0;
        end else if (inc_now && cycle_counter < `PSCR_CYCLE_MAX) begin
            copy_pend <= 1'b1;
        end else if (nv_state == NV_IDLE && !host_wr) begin
            copy_pend <= 1'b0;
        end
    end

    // =================================================
    // Command handling
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            pend  <= 1'b0;
            cmd_q <= '0;
        end else begin
            pend <= cmd_valid_in && !pend;
            if (cmd_valid_in && !pend) begin
                cmd_q <= cmd_in;
            end
        end
    end

    // Outcome of the held command, in priority order
    always_comb begin
        next_ec = `PSCR_EC_OK;
        if (cmd_q.abort) begin
            next_ec = `PSCR_EC_UNKNOWN;
        end else if (cmd_q.code >= `PSCR_CMD_RSV_LO &&
                     cmd_q.code <= `PSCR_CMD_RSV_HI) begin
            next_ec = `PSCR_EC_RSVD;
        end else if (!own_code(cmd_q.code)) begin
            next_ec = `PSCR_EC_UNSUP;
        end else if (cmd_q.write) begin
            if (sealed_in || cmd_q.code == `PSCR_CMD_STATUS) begin
                next_ec = `PSCR_EC_DENIED;
            end else if (cmd_q.bad_size) begin
                next_ec = `PSCR_EC_SIZE;
            end else if (!init_done_flag || nv_state != NV_IDLE) begin
                next_ec = `PSCR_EC_BUSY;
            end else if (cmd_q.code == `PSCR_CMD_DVOLT &&
                         (cmd_q.wdata < `PSCR_DVOLT_MIN ||
                          cmd_q.wdata > `PSCR_DVOLT_MAX)) begin
                next_ec = `PSCR_EC_RANGE;
            end
        end
    end

    assign host_wr = pend && cmd_q.write && next_ec == `PSCR_EC_OK;

    // Error field follows the most recent command
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            error_code_field <= `PSCR_EC_OK;
        end else if (pend) begin
            error_code_field <= next_ec;
        end
    end

    // =================================================
    // Backing store port and write timing
    assign nv_rd_addr = nv_index(cmd_in.code, capacity_mode_in);
    assign nv_wr_en   = host_wr ||
                        (nv_state == NV_IDLE && copy_pend);
    assign nv_wr_addr = host_wr ? nv_index(cmd_q.code, capacity_mode_in)
                                : `PSCR_NV_CYCLE;
    assign nv_wr_data = host_wr ? cmd_q.wdata : cycle_counter;

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            nv_state <= NV_IDLE;
            nv_cnt   <= 4'h0;
        end else begin
            unique case (nv_state)
                NV_IDLE: begin
                    if (nv_wr_en) begin
                        nv_state <= NV_BUSY;
                        nv_cnt   <= `PSCR_NV_WR_CYCLES;
                    end
                end
                NV_BUSY: begin
                    nv_cnt <= nv_cnt - 4'h1;
                    if (nv_cnt == 4'h1) begin
                        nv_state <= NV_IDLE;
                    end
                end
            endcase
        end
    end

    pscr_nvstore u_store (
        .core_clk_in (core_clk_in),
        .sys_rst_in  (sys_rst_in),
        .wr_en_in    (nv_wr_en),
        .wr_addr_in  (nv_wr_addr),
        .wr_data_in  (nv_wr_data),
        .rd_addr_in  (nv_rd_addr),
        .rd_data_out (nv_rd_data)
    );

    // =================================================
    // Status word and answers
    logic [15:0] status_w;
    assign status_w = {gauge_in.overcharge_alarm,
                       gauge_in.stop_charge_alarm, 1'b0,
                       gauge_in.overheat_alarm,
                       gauge_in.stop_discharge_alarm, 1'b0,
                       capacity_mode_in ? gauge_in.low_capacity_alarm_p
                                        : gauge_in.low_capacity_alarm_i,
                       capacity_mode_in ? gauge_in.low_time_alarm_p
                                        : gauge_in.low_time_alarm_i,
                       init_done_flag, draining_flag,
                       gauge_in.full_flag, gauge_in.empty_flag,
                       error_code_field};

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            pack_status_word_out <= 16'h0000;
            nv_busy_out          <= 1'b0;
        end else begin
            pack_status_word_out <= status_w;
            nv_busy_out          <= nv_state == NV_BUSY || copy_pend;
        end
    end

    // One pulse per command; writes and refused reads answer zero
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            rsp_valid_out <= 1'b0;
            rsp_data_out  <= 16'h0000;
        end else begin
            rsp_valid_out <= pend;
            if (!pend || cmd_q.write || next_ec != `PSCR_EC_OK) begin
                rsp_data_out <= 16'h0000;
            end else if (cmd_q.code == `PSCR_CMD_STATUS) begin
                rsp_data_out <= status_w;
            end else if (cmd_q.code == `PSCR_CMD_CYCLE) begin
                rsp_data_out <= cycle_counter;
            end else begin
                rsp_data_out <= nv_rd_data;
            end
        end
    end

    // Power scale exponent, held beside the stored spec word
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            power_scale_exp_out <=
                5'(`PSCR_SPEC_RST >> `PSCR_SPEC_VSC_LSB & 16'h000f) +
                5'(`PSCR_SPEC_RST >> `PSCR_SPEC_ISC_LSB & 16'h000f);
        end else if (host_wr && cmd_q.code == `PSCR_CMD_SPEC) begin
            power_scale_exp_out <=
                5'(cmd_q.wdata[`PSCR_SPEC_VSC_LSB +: 4]) +
                5'(cmd_q.wdata[`PSCR_SPEC_ISC_LSB +: 4]);
        end
    end

    // =================================================
    // Checks
    chk_chg_clear: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in) chg_det |=> !draining_flag)
        else $error("drain flag not cleared on charge");
    chk_drain_dsg_set: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in) (dsg_det && !chg_det) |=> draining_flag)
        else $error("drain flag not set on discharge");
    chk_drain_hold: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in) (!quiet && !dsg_det && !chg_det)
        |=> $stable(draining_flag))
        else $error("drain flag moved without cause");
    chk_init_wait: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in) !init_done_flag && !sec_tick
        |=> !init_done_flag)
        else $error("init flag set early");
    chk_cycle_sat: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in) cycle_counter <= `PSCR_CYCLE_MAX)
        else $error("cycle count above limit");
    chk_cycle_copy: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        $rose(copy_pend) |-> ##[0:6] (nv_wr_en && !host_wr))
        else $error("cycle count not copied");
    chk_sealed_deny: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in) pend && cmd_q.write && sealed_in
        && own_code(cmd_q.code) && !cmd_q.abort
        |-> !host_wr ##1 error_code_field == `PSCR_EC_DENIED)
        else $error("sealed write not refused");
    chk_err_update: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in) pend && !sys_rst_in |=> rsp_valid_out
        && error_code_field == $past(next_ec))
        else $error("error field not updated");
    chk_status_ec: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        !sys_rst_in |=> pack_status_word_out[7:0] == {$past(init_done_flag),
        $past(draining_flag), $past(status_w[5:4]),
        $past(error_code_field)})
        else $error("status word low byte wrong");
endmodule // pscr_regs

`default_nettype wire

// ---- test_pscr_regs.sv ----
// Purpose: Self-checking bench for the status and cycle bank
// Assumes: One second shortened to 20 cycles
// Notes:   Init checks first, then row table, awkward cases after it
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) checks++; if ((a) !== (b)) begin \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); \
    miscompares++; end

module test_pscr_regs;
    import pscr_pkg::*;
    // Row: {write, abort, bad_size, sealed}, code, wdata, rdata, error
    typedef logic [47:0] pscr_row_t;
    pscr_row_t rows [16] = '{48'h0_18_0000_1130_0, 48'h0_19_0000_3840_0,
        48'h0_1a_0000_0031_0, 48'h0_17_0000_0000_0, 48'h8_19_1b57_0000_5,
        48'h8_19_4651_0000_5, 48'h8_19_1b58_0000_0, 48'h0_19_0000_1b58_0,
        48'h8_16_0000_0000_4, 48'h0_70_0000_0000_2, 48'h0_7f_0000_0000_2,
        48'h0_20_0000_0000_3, 48'h4_18_0000_0000_7, 48'ha_18_0001_0000_6,
        48'h9_18_0001_0000_4, 48'h1_18_0000_1130_0};
    logic core_clk_in = 0, sys_rst_in = 1, cmd_valid_in, rsp_valid_out;
    logic chg_term_in = 0, charge_switch_in = 1, sealed_in = 0;
    logic capacity_mode_in = 0, cycle_threshold_select_in = 0;
    logic dsg_mah_pulse_in = 0, nv_busy_out;
    logic signed [15:0] current_ma_in = 0;
    logic [15:0] quit_ma_in = 20, dsg_detect_ma_in = 50;
    logic [15:0] chg_detect_ma_in = 100, full_cap_in = 10, d;
    logic [15:0] cycle_discharge_amount_in = 3, rsp_data_out;
    logic [15:0] pack_status_word_out;
    logic [7:0] relax_s_in = 2;
    logic [6:0] cycle_discharge_percent_in = 20;
    logic [4:0] power_scale_exp_out;
    pscr_cmd_t cmd_in;
    pscr_gauge_t gauge_in = '0;
    int checks = 0, miscompares = 0;

    always #10 core_clk_in = ~core_clk_in;

    pscr_host_model host (.rsp_valid_in(rsp_valid_out),
        .rsp_data_in(rsp_data_out), .clk_in(core_clk_in),
        .cmd_valid_out(cmd_valid_in), .cmd_out(cmd_in));
    pscr_regs #(.SEC_CYCLES(20)) dut (.core_clk_in, .sys_rst_in,
        .cmd_valid_in, .cmd_in, .gauge_in, .current_ma_in, .quit_ma_in,
        .dsg_detect_ma_in, .chg_detect_ma_in, .relax_s_in, .chg_term_in,
        .charge_switch_in, .sealed_in, .capacity_mode_in,
        .cycle_threshold_select_in, .cycle_discharge_amount_in,
        .cycle_discharge_percent_in, .full_cap_in, .dsg_mah_pulse_in,
        .rsp_valid_out, .rsp_data_out, .pack_status_word_out,
        .power_scale_exp_out, .nv_busy_out);

    // ==========================================================
    // Helpers; a store copy must finish before the next write
    task automatic idle;
        int n;
        n = 0;
        while (nv_busy_out !== 1'b0 && n < 20) begin
            @(negedge core_clk_in);
            n++;
        end
        @(posedge core_clk_in);
    endtask
    task automatic rd(input logic [7:0] c, input logic [15:0] e);
        idle();
        host.xfer(c, 16'h0, 3'h0, d);
        `CHK(d, e)
    endtask
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge core_clk_in) dsg_mah_pulse_in <= 1'b1;
            @(posedge core_clk_in) dsg_mah_pulse_in <= 1'b0;
        end
    endtask
    task automatic drain(input logic signed [15:0] c, input logic sw, tm,
                         input int w, input logic ex);
        @(posedge core_clk_in);
        current_ma_in <= c;
        charge_switch_in <= sw;
        chg_term_in <= tm;
        repeat (w) @(negedge core_clk_in);
        `CHK(pack_status_word_out[6], ex)
    endtask
    task automatic close_out;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Watchdog, far beyond the expected few hundred cycles
    initial begin
        #400000;
        miscompares++;
        close_out();
    end

    initial begin
        repeat (12) @(posedge core_clk_in);
        sys_rst_in <= 1'b0;
        host.xfer(8'h19, 16'h3840, 3'h4, d); // Write before init is busy
        @(negedge core_clk_in);
        `CHK(pack_status_word_out[7:0], 8'h01)
        repeat (30) @(negedge core_clk_in);
        `CHK(pack_status_word_out[7], 1'b1)
        `CHK(power_scale_exp_out, 5'h00)
        foreach (rows[i]) begin
            idle();
            sealed_in <= rows[i][44];
            host.xfer(rows[i][43:36], rows[i][35:20], rows[i][47:45], d);
            `CHK(d, rows[i][19:4])
            @(negedge core_clk_in);
            `CHK(pack_status_word_out[3:0], rows[i][3:0])
        end
        @(posedge core_clk_in) sealed_in <= 1'b0;
        idle();
        host.xfer(8'h17, 16'h0005, 3'h4, d);
        host.xfer(8'h18, 16'h0001, 3'h4, d); // Store still busy
        @(negedge core_clk_in);
        `CHK(pack_status_word_out[3:0], 4'h1)
        `CHK(nv_busy_out, 1'b1)
        pulse(3);
        rd(8'h17, 16'h0006);
        host.xfer(8'h17, 16'hfffe, 3'h4, d);
        pulse(3);
        rd(8'h17, 16'hfffe);
        host.xfer(8'h17, 16'h0000, 3'h4, d);
        @(posedge core_clk_in) cycle_threshold_select_in <= 1'b1;
        pulse(2);
        rd(8'h17, 16'h0001);
        @(posedge core_clk_in) gauge_in <= '1;
        repeat (3) @(negedge core_clk_in);
        `CHK(pack_status_word_out[15:4], 12'hdbf)
        @(posedge core_clk_in) gauge_in <= 10'b0000010100;
        capacity_mode_in <= 1'b1;
        repeat (3) @(negedge core_clk_in);
        `CHK(pack_status_word_out[9:8], 2'b11)
        drain(150, 1, 0, 4, 0);
        drain(-60, 1, 0, 4, 1);
        drain(60, 1, 0, 4, 1);
        drain(150, 1, 0, 4, 0);
        drain(10, 0, 0, 4, 1);
        drain(150, 1, 0, 4, 0);
        drain(10, 1, 1, 4, 1);
        drain(150, 1, 0, 4, 0);
        drain(10, 1, 0, 4, 0);
        drain(10, 1, 0, 70, 1);
        // Mid-run full reset: flags and count return to defaults
        @(posedge core_clk_in) sys_rst_in <= 1'b1;
        @(posedge core_clk_in) sys_rst_in <= 1'b0;
        @(negedge core_clk_in);
        `CHK(pack_status_word_out, 16'h0000)
        rd(8'h17, 16'h0000);
        `CHK(pack_status_word_out[7:0], 8'h00)
        close_out();
    end
endmodule // test_pscr_regs

`default_nettype wire
